// ---- testbench.sv ----
// Purpose: Self-checking bench for the capture FIFO control
// Assumes: Register offsets are word indices; datapath model fills to a target level
// Notes:   One idle cycle separates bus transfers
`timescale 1ns/1ps
`include "ycf_consts.svh"
module testbench
  import ycf_pkg::*;
;
  localparam logic [15:0] DATA_PORT = 16'h2826;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, err, fifo_transmit = 1'b0, frame_start, frame_end;
  logic        fifo_clear, capture_reset, capture_enable, fifo_full, fifo_empty, irq;
  logic [7:0]  valid_size, want = 8'h00;
  ycf_stream_t stream;
  int          n_mismatch = 0, compares = 0;

  always #4 pclk = ~pclk;

  ycf_fifo_control dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_transmit(fifo_transmit), .stream(stream),
    .frame_start(frame_start), .frame_end(frame_end), .fifo_clear(fifo_clear),
    .capture_reset(capture_reset), .capture_enable(capture_enable),
    .valid_size(valid_size), .fifo_full(fifo_full), .fifo_empty(fifo_empty), .irq(irq));
  ycf_dp_model dp_u (
    .pclk(pclk), .presetn(presetn), .want_level(want), .valid_size(valid_size),
    .stream(stream), .frame_start(frame_start), .frame_end(frame_end));

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {a[13:0], 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    // Taken at the accepting edge, before that edge's register updates
    rd       = prdata;
    err      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic fill(input logic [7:0] v);
    want <= v;
    repeat (100) begin
      @(posedge pclk);
      if (valid_size === v) break;
    end
    chk({24'h0, valid_size}, {24'h0, v});
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #50us;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`YCF_OFF_CONTROL, 32'h0);
    rchk(`YCF_OFF_FIFO_SIZE, 32'h3f);
    fifo_transmit <= 1'b1;
    rchk(`YCF_OFF_CONTROL, 32'h1);
    fifo_transmit <= 1'b0;
    rchk(`YCF_OFF_CONTROL, 32'h0);
    // Size 16: quarter is 4, half is 8
    apb(1'b1, `YCF_OFF_FIFO_SIZE, 32'h10);
    apb(1'b1, `YCF_OFF_INT_MASK, 32'h1);
    fill(8'h06);
    rchk(`YCF_OFF_INT_STATUS, 32'h0);
    apb(1'b1, `YCF_OFF_CONTROL, 32'h20);
    rchk(`YCF_OFF_CONTROL, 32'h20);
    chk({31'h0, irq}, 32'h1);
    rchk(`YCF_OFF_INT_STATUS, 32'h1);
    // The read clears status at the accepting edge; irq is seen low one edge later
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    fill(8'h0a);
    rchk(`YCF_OFF_INT_STATUS, 32'h0);
    apb(1'b1, `YCF_OFF_CONTROL, 32'h30);
    rchk(`YCF_OFF_INT_STATUS, 32'h1);
    apb(1'b1, `YCF_OFF_INT_MASK, 32'h0);
    fill(8'h10);
    chk({31'h0, fifo_full}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rchk(`YCF_OFF_INT_STATUS, 32'h2);
    apb(1'b1, `YCF_OFF_CONTROL, 32'h30);
    @(posedge pclk);
    chk({24'h0, valid_size}, 32'h10);
    // Three pops move the read pointer so the clear has something to undo
    fill(8'h0d);
    rchk(`YCF_OFF_RD_PTR, 32'h3);
    apb(1'b1, `YCF_OFF_CONTROL, 32'h34);
    want <= 8'h00;
    @(posedge pclk);
    chk({24'h0, valid_size}, 32'h0);
    chk({31'h0, fifo_empty}, 32'h1);
    rchk(`YCF_OFF_RD_PTR, 32'h0);
    rchk(`YCF_OFF_CONTROL, 32'h30);
    repeat (2) rchk(DATA_PORT, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `YCF_OFF_CAPTURE, 32'h80);
    @(posedge pclk);
    chk({31'h0, capture_reset}, 32'h1);
    rchk(`YCF_OFF_INT_STATUS, 32'h0);
    apb(1'b1, `YCF_OFF_CAPTURE, 32'h1);
    repeat (40) if (capture_enable !== 1'b1) @(posedge pclk);
    rchk(`YCF_OFF_CAPTURE, 32'h1);
    apb(1'b1, `YCF_OFF_CAPTURE, 32'h0);
    repeat (40) if (capture_enable !== 1'b0) @(posedge pclk);
    rchk(`YCF_OFF_CAPTURE, 32'h0);
    give_verdict();
  end
endmodule

// ---- ycf_consts.svh ----
// Purpose: Offsets, field positions, reset values and event indices for the capture FIFO control
// Assumes: Offsets are register indices; the APB byte address is four times the index
// Notes:   Definitions only
`ifndef YCF_CONSTS_SVH
`define YCF_CONSTS_SVH

`define YCF_ADDR_W         16
`define YCF_OFF_CONTROL    16'h2820
`define YCF_OFF_FIFO_SIZE  16'h2824
`define YCF_OFF_VALID_SIZE 16'h2828
`define YCF_OFF_INT_STATUS 16'h2830
`define YCF_OFF_INT_MASK   16'h2834
`define YCF_OFF_CAPTURE    16'h280c
`define YCF_OFF_RD_PTR     16'h282a
`define YCF_OFF_WR_PTR     16'h282c
`define YCF_CTRL_RESET     16'h0000
`define YCF_BIT_DIR        0
`define YCF_BIT_CLEAR      2
`define YCF_THR_LO         4
`define YCF_THR_HI         5
`define YCF_BIT_CAP_RESET  7
`define YCF_SIZE_RESET     8'h3f
`define YCF_EV_THRESHOLD   0
`define YCF_EV_FULL        1
`define YCF_EV_EMPTY       2
`define YCF_NUM_EV         3

`endif

// ---- ycf_dp_model.sv ----
// Purpose: Datapath model that fills or drains toward a target and frames video
// Assumes: Level feedback from valid_size
// Notes:   Steps every other cycle so the registered level settles first
`timescale 1ns/1ps
module ycf_dp_model
  import ycf_pkg::*;
#(
  parameter int FRAME = 16
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Target and level
  input  wire logic [7:0] want_level,
  input  wire logic [7:0] valid_size,
  // Datapath
  output ycf_stream_t     stream,
  output logic            frame_start,
  output logic            frame_end
);
  logic [7:0] tick;
  wire        idle = !stream.push && !stream.pop;
  assign frame_start = tick == 8'h00;
  assign frame_end   = tick == 8'(FRAME - 2);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick   <= 8'h00;
      stream <= '0;
    end else begin
      tick        <= tick == 8'(FRAME - 1) ? 8'h00 : tick + 8'h01;
      stream.push <= idle && valid_size < want_level;
      stream.pop  <= idle && valid_size > want_level;
      // Data word is unused by the block, so keep it moving
      stream.data <= ~stream.data;
    end
  end
endmodule

// ---- ycf_fifo_control.sv ----
// Purpose: APB control of the video capture FIFO: threshold, clear, interrupts; direction is read back from fifo_transmit
// Assumes: Single pclk domain; push/pop/frame strobes are synchronous to pclk
// Notes:   The FIFO storage itself lives in the datapath; this block tracks its level
//          and pointers. Register offsets are word indices, so paddr[15:2] is compared.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "ycf_consts.svh"
module ycf_fifo_control
  import ycf_pkg::*;
#(
  parameter int LVL_W = 8
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Datapath
  input  wire logic        fifo_transmit,
  input  wire ycf_stream_t stream,
  input  wire logic        frame_start,
  input  wire logic        frame_end,
  output logic             fifo_clear,
  output logic             capture_reset,
  output logic             capture_enable,
  output logic [LVL_W-1:0] valid_size,
  output logic             fifo_full,
  output logic             fifo_empty,
  // Interrupt
  output logic             irq
);
  logic [1:0]          thr_sel;
  logic [LVL_W-1:0]    fifo_size;
  logic [`YCF_NUM_EV-1:0] int_status;
  logic [`YCF_NUM_EV-1:0] int_mask;
  logic [`YCF_NUM_EV-1:0] next_status;
  logic                cap_req;
  logic                cap_reset;
  logic                direction;
  logic                trigger;
  logic                empty_d;
  ycf_cap_t            cap_state;
  ycf_cap_t            next_cap;
  logic [LVL_W-1:0]    wr_ptr;
  logic [LVL_W-1:0]    rd_ptr;

  // Odd documented offsets would alias if compared as byte addresses
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a[15:2] == idx[13:0]);
  endfunction

  // Pointers wrap at the programmed size so they only index the live part of the buffer
  function automatic logic [LVL_W-1:0] ptr_step(input logic [LVL_W-1:0] p,
                                                 input logic [LVL_W-1:0] size);
    logic [LVL_W:0] up;
    up       = {1'b0, p} + 1'b1;
    ptr_step = (up >= {1'b0, size}) ? '0 : up[LVL_W-1:0];
  endfunction

  // Bus decode; every access completes with no wait state
  wire access    = psel & penable;
  wire wr        = access & pwrite;
  wire rd        = access & ~pwrite;
  wire sel_ctrl  = hit(paddr, `YCF_OFF_CONTROL);
  wire sel_size  = hit(paddr, `YCF_OFF_FIFO_SIZE);
  wire sel_valid = hit(paddr, `YCF_OFF_VALID_SIZE);
  wire sel_stat  = hit(paddr, `YCF_OFF_INT_STATUS);
  wire sel_mask  = hit(paddr, `YCF_OFF_INT_MASK);
  wire sel_cap   = hit(paddr, `YCF_OFF_CAPTURE);
  wire sel_rptr  = hit(paddr, `YCF_OFF_RD_PTR);
  wire sel_wptr  = hit(paddr, `YCF_OFF_WR_PTR);
  wire mapped    = sel_ctrl | sel_size | sel_valid | sel_stat | sel_mask | sel_cap |
                   sel_rptr | sel_wptr;
  wire wr_ctrl   = wr & sel_ctrl & pstrb[0];
  wire wr_clear  = wr_ctrl & pwdata[`YCF_BIT_CLEAR];
  wire stat_rd   = rd & sel_stat;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  ycf_level #(
    .LVL_W(LVL_W)
  ) u_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (fifo_clear),
    .thr_sel   (thr_sel),
    .fifo_size (fifo_size),
    .push      (stream.push),
    .pop       (stream.pop),
    .level     (valid_size),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .trigger   (trigger)
  );

  // Read and write pointers follow the same accepted push and pop as the level
  wire push_ok = stream.push & ~fifo_full;
  wire pop_ok  = stream.pop & ~fifo_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (fifo_clear) begin
      // Clear beats a push or pop in the same cycle, as it does for the level
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= ptr_step(wr_ptr, fifo_size);
      end
      if (pop_ok) begin
        rd_ptr <= ptr_step(rd_ptr, fifo_size);
      end
    end
  end

  // Clear wiring is a one-cycle pulse taken straight from the write
  assign fifo_clear    = wr_clear;
  assign capture_reset = cap_reset;
  assign capture_enable = (cap_state == ycf_cap_active) || (cap_state == ycf_cap_stopping);

  // Read data: reserved bits and the clear bit read zero
  wire [15:0] ctrl_rd = {10'h000, thr_sel, 1'b0, 1'b0, 1'b0, direction};
  wire [31:0] rd_mux  =
    sel_ctrl  ? {16'h0000, ctrl_rd} :
    sel_size  ? {{(32-LVL_W){1'b0}}, fifo_size} :
    sel_valid ? {{(32-LVL_W){1'b0}}, valid_size} :
    sel_stat  ? {{(32-`YCF_NUM_EV){1'b0}}, int_status} :
    sel_mask  ? {{(32-`YCF_NUM_EV){1'b0}}, int_mask} :
    sel_rptr  ? {{(32-LVL_W){1'b0}}, rd_ptr} :
    sel_wptr  ? {{(32-LVL_W){1'b0}}, wr_ptr} :
    sel_cap   ? {31'h00000000, capture_enable} :
                32'h00000000;
  assign prdata = rd ? rd_mux : 32'h00000000;

  // Events: rising threshold, rising full, and a true drain to empty.
  // A clear is not a drain, so the empty event is masked by the clear pulse.
  logic trig_d;
  logic full_d;
  wire  ev_thr   = trigger & ~trig_d;
  wire  ev_full  = fifo_full & ~full_d;
  wire  ev_empty = fifo_empty & ~empty_d & ~fifo_clear;
  wire [`YCF_NUM_EV-1:0] events = {ev_empty, ev_full, ev_thr};

  // Set wins over the read-clear in the same cycle
  always_comb begin
    next_status = stat_rd ? '0 : int_status;
    next_status = next_status | events;
  end

  assign irq = |(int_status & int_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d  <= 1'b0;
      full_d  <= 1'b0;
      empty_d <= 1'b1;
      int_status <= '0;
    end else begin
      trig_d  <= trigger;
      full_d  <= fifo_full;
      // Track empty across a clear so the jump to empty raises no event
      empty_d <= fifo_empty | fifo_clear;
      int_status <= next_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_sel <= 2'b00;
    end else if (wr_ctrl) begin
      thr_sel <= pwdata[`YCF_THR_HI:`YCF_THR_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_size <= LVL_W'(`YCF_SIZE_RESET);
      int_mask  <= '0;
    end else if (wr && pstrb[0]) begin
      if (sel_size) begin
        fifo_size <= pwdata[LVL_W-1:0];
      end
      if (sel_mask) begin
        int_mask <= pwdata[`YCF_NUM_EV-1:0];
      end
    end
  end

  // Direction follows the datapath configuration input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction <= 1'b0;
    end else begin
      direction <= fifo_transmit;
    end
  end

  // Capture start/stop and capture-module reset
  wire wr_cap = wr & sel_cap & pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_req   <= 1'b0;
      cap_reset <= 1'b0;
    end else begin
      cap_reset <= wr_cap & pwdata[`YCF_BIT_CAP_RESET];
      if (wr_cap) begin
        cap_req <= pwdata[0];
      end
    end
  end

  always_comb begin
    next_cap = cap_state;
    case (cap_state)
      ycf_cap_idle: begin
        if (cap_req) begin
          next_cap = ycf_cap_wait_frame;
        end
      end
      ycf_cap_wait_frame: begin
        if (!cap_req) begin
          next_cap = ycf_cap_idle;
        end else if (frame_start) begin
          next_cap = ycf_cap_active;
        end
      end
      ycf_cap_active: begin
        if (!cap_req) begin
          next_cap = ycf_cap_stopping;
        end
      end
      ycf_cap_stopping: begin
        if (cap_req) begin
          next_cap = ycf_cap_active;
        end else if (frame_end) begin
          next_cap = ycf_cap_idle;
        end
      end
      default: next_cap = ycf_cap_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_state <= ycf_cap_idle;
    end else if (cap_reset) begin
      cap_state <= ycf_cap_idle;
    end else begin
      cap_state <= next_cap;
    end
  end
endmodule

// ---- ycf_fifo_control_sva.sv ----
// Purpose: Port-level assertions for the capture FIFO control
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound into every ycf_fifo_control
`timescale 1ns/1ps
`include "ycf_consts.svh"
module ycf_fifo_control_sva
#(
  parameter int LVL_W = 8
) (
  // APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [15:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  // Datapath and interrupt
  input wire logic             fifo_transmit,
  input wire logic             frame_start,
  input wire logic             frame_end,
  input wire logic             fifo_clear,
  input wire logic             capture_enable,
  input wire logic             capture_reset,
  input wire logic [LVL_W-1:0] valid_size,
  input wire logic             fifo_empty,
  input wire logic             irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam logic [15:0] CTL_IDX = `YCF_OFF_CONTROL;
  wire ctl = psel && penable && paddr == {CTL_IDX[13:0], 2'b00};
  wire rd  = ctl && !pwrite;
  wire clr = ctl && pwrite && pwdata[`YCF_BIT_CLEAR];

  a_clear_fires: assert property (clr |-> fifo_clear)
    else $error("clear write lost");
  a_clear_cause: assert property (fifo_clear |-> clr)
    else $error("clear without cause");
  a_clear_done: assert property (fifo_clear |=> valid_size == '0 && fifo_empty)
    else $error("clear too slow");
  a_clear_reads: assert property (rd |-> !prdata[`YCF_BIT_CLEAR])
    else $error("clear bit reads one");
  a_resv_zero: assert property (rd |-> prdata[15:6] == '0 && !prdata[3] && !prdata[1])
    else $error("reserved bits set");
  a_dir_bit: assert property (rd |-> prdata[0] == $past(fifo_transmit))
    else $error("direction bit wrong");
  a_start_wait: assert property ($rose(capture_enable) |-> $past(frame_start))
    else $error("capture began off frame");
  // A capture-module reset may also end a capture, with no frame end
  a_stop_frame: assert property ($fell(capture_enable) |-> $past(frame_end) || $past(capture_reset))
    else $error("capture ended off frame");
  c_clear: cover property (fifo_clear);
  c_start: cover property ($rose(capture_enable));
  c_irq: cover property ($rose(irq));
endmodule

bind ycf_fifo_control ycf_fifo_control_sva #(.LVL_W(LVL_W)) sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .fifo_transmit(fifo_transmit),
  .frame_start(frame_start), .frame_end(frame_end), .fifo_clear(fifo_clear),
  .capture_enable(capture_enable), .capture_reset(capture_reset),
  .valid_size(valid_size), .fifo_empty(fifo_empty),
  .irq(irq));

// ---- ycf_level.sv ----
// Purpose: Fill-level counter and threshold decode for the capture FIFO
// Assumes: Push and pop come from logic on pclk
// Notes:   Clear wins over a push or pop in the same cycle
`timescale 1ns/1ps
module ycf_level
  import ycf_pkg::*;
#(
  parameter int LVL_W = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             clear,
  input  wire logic [1:0]       thr_sel,
  input  wire logic [LVL_W-1:0] fifo_size,
  input  wire logic             push,
  input  wire logic             pop,
  // Status
  output logic [LVL_W-1:0]      level,
  output logic                  full,
  output logic                  empty,
  output logic                  trigger
);
  logic [LVL_W-1:0] next_level;
  wire              do_push = push & ~full;
  wire              do_pop  = pop & ~empty;
  wire [LVL_W-1:0]  quarter = fifo_size >> 2;
  wire [LVL_W-1:0]  half    = fifo_size >> 1;

  assign full  = (level >= fifo_size) && (fifo_size != '0);
  assign empty = (level == '0);

  always_comb begin
    next_level = level;
    if (clear) begin
      next_level = '0;
    end else if (do_push && !do_pop) begin
      next_level = level + 1'b1;
    end else if (do_pop && !do_push) begin
      next_level = level - 1'b1;
    end
  end

  always_comb begin
    case (ycf_thr_t'(thr_sel))
      ycf_thr_never:    trigger = 1'b0;
      ycf_thr_quarter:  trigger = (level > quarter) && (level < half);
      ycf_thr_half:     trigger = (level > half);
      default:          trigger = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end
endmodule

// ---- ycf_pkg.sv ----
// Purpose: Types shared by the capture FIFO control files
// Assumes: ycf_consts.svh supplies the numbers
// Notes:   Types only
package ycf_pkg;
  typedef enum logic [1:0] {
    ycf_thr_never,
    ycf_thr_reserved,
    ycf_thr_quarter,
    ycf_thr_half
  } ycf_thr_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [31:0] data;
  } ycf_stream_t;

  typedef enum logic [1:0] {
    ycf_cap_idle,
    ycf_cap_wait_frame,
    ycf_cap_active,
    ycf_cap_stopping
  } ycf_cap_t;
endpackage
